// ===== rtl/bit_and_branch_decoder.sv
// Functional notes
// - 82: carry AND bit, two cycles
// - B0: carry AND inverted bit, bit kept
// - 72: carry OR bit, two cycles
// - A0: carry OR inverted bit, two cycles
// - A2: bit copied into carry, one cycle
// - 92: carry written to bit, two cycles
// - 10: branch on set bit, clear it
// - 20/30: branch on bit set/clear, kept
// - 40/50: branch on carry set/clear
// - 60/70: branch on accumulator zero/nonzero
// - 73: pc gets accumulator plus data pointer
// - B5/B4: compare accumulator, branch if unequal
// - B8-BF register, B6/B7 indirect compare
// - D8-DF, D5: decrement, branch if nonzero
// - Page target replaces low eleven bits
// - 12/02 use full sixteen-bit target
// - Relative offset signed, from next instruction
// - Direct reaches low RAM and SFRs
// - Indirect address from R0 or R1
// - Sixteen-bit constant from bytes two, three
`timescale 1ns/1ps
module bit_and_branch_decoder
  import bitbranch_pkg::*;
#(
  parameter int DIV = CLKS_PER_MCYCLE
) (
  input wire logic clk,          // Core clock, 250 MHz
  input wire logic rst_b,        // Asynchronous reset, active low
  input wire logic instr_valid,  // Instruction offered
  output logic instr_ready,      // Decoder idle and taking
  input wire instr_t instr,      // Opcode, operand bytes and pc
  output oreq_t oreq,            // Operand addresses for the core
  input wire opnd_t opnd,        // Operand values from the core
  output logic done,             // One-cycle completion pulse
  output res_t res               // Results, held until next done
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // Waiting for an instruction
    ST_EXEC = 2'b01   // Counting machine cycles
  } state_t;

  logic rst_meta_r;        // Reset synchroniser first stage
  logic rst_sync_b;        // Synchronised reset, active low
  logic tick;              // Machine cycle enable
  state_t st_r;            // Sequencer state
  state_t st_nxt;          // Next state
  instr_t instr_r;         // Instruction in execution
  instr_t instr_nxt;       // Next held instruction
  logic [1:0] left_r;      // Machine cycles still to run
  logic [1:0] left_nxt;    // Next remaining count
  logic [1:0] seen_r;      // Machine cycles run so far
  logic [1:0] seen_nxt;    // Next run count
  res_t res_r;             // Registered results
  res_t res_nxt;           // Next results
  logic done_r;            // Registered completion
  logic done_nxt;          // Next completion
  res_t res_c;             // Results computed from operands
  logic accept;            // Instruction taken this clock
  logic finish;            // Last machine cycle ends this clock
  logic [15:0] pc_after;   // Address of the following instruction
  logic [15:0] rel_short;  // Target with offset in byte two
  logic [15:0] rel_long;   // Target with offset in byte three
  logic [15:0] page_tgt;   // In-page target
  logic [7:0] dec_val;     // Decremented byte
  // Latest clock after accept at which a one-cycle op may still show done
  localparam int QUICK_MAX = DIV + 1;

  // Release reset through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // Machine cycle enable
  mcycle_divider #(.DIV(DIV)) u_div (
    .clk(clk),
    .rst_b(rst_sync_b),
    .tick(tick)
  );

  // Operand addresses follow the held instruction
  always_comb begin
    oreq.dir_addr = instr_r.b1;
    oreq.dir_is_sfr = instr_r.b1[7];
    oreq.bit_addr = instr_r.b1;
    oreq.reg_sel = instr_r.op[2:0];
    oreq.ind_sel = instr_r.op[0];
  end

  // Branch target arithmetic
  always_comb begin
    pc_after = 16'(instr_r.pc + 16'(op_len(instr_r.op)));
    rel_short = rel_add(pc_after, instr_r.b1);
    rel_long = rel_add(pc_after, instr_r.b2);
    page_tgt = {pc_after[15:PAGE_BITS], instr_r.op[7:5], instr_r.b1};
    dec_val = 8'((instr_r.op == OP_DEC_DIR ? opnd.dir_byte : opnd.reg_byte) - 8'h01);
  end

  // Execute the held instruction against the operands
  always_comb begin
    res_c = '0;
    res_c.pc = pc_after;
    res_c.ret_pc = pc_after;
    casez (instr_r.op)
      OP_CLR_C, OP_SET_C, OP_INV_C: begin
        res_c.carry_we = 1'b1;
        res_c.carry = instr_r.op == OP_INV_C ? ~opnd.carry : instr_r.op == OP_SET_C;
      end
      OP_CLR_BIT, OP_SET_BIT, OP_INV_BIT: begin
        res_c.bit_we = 1'b1;
        res_c.bit_val = instr_r.op == OP_INV_BIT ? ~opnd.bit_val : instr_r.op == OP_SET_BIT;
      end
      OP_AND_C_BIT: begin
        res_c.carry_we = 1'b1;
        res_c.carry = opnd.carry & opnd.bit_val;
      end
      OP_AND_C_NBIT: begin
        res_c.carry_we = 1'b1;
        res_c.carry = opnd.carry & ~opnd.bit_val;
      end
      OP_OR_C_BIT: begin
        res_c.carry_we = 1'b1;
        res_c.carry = opnd.carry | opnd.bit_val;
      end
      OP_OR_C_NBIT: begin
        res_c.carry_we = 1'b1;
        res_c.carry = opnd.carry | ~opnd.bit_val;
      end
      OP_MOV_C_BIT: begin
        res_c.carry_we = 1'b1;
        res_c.carry = opnd.bit_val;
      end
      OP_MOV_BIT_C: begin
        res_c.bit_we = 1'b1;
        res_c.bit_val = opnd.carry;
      end
      OP_TEST_CLR: begin
        // Bit is cleared only when the branch is taken
        if (opnd.bit_val) begin
          res_c.pc = rel_long;
          res_c.bit_we = 1'b1;
          res_c.bit_val = 1'b0;
        end
      end
      OP_JB, OP_JNB: begin
        if (opnd.bit_val == (instr_r.op == OP_JB)) begin
          res_c.pc = rel_long;
        end
      end
      OP_JC, OP_JNC: begin
        if (opnd.carry == (instr_r.op == OP_JC)) begin
          res_c.pc = rel_short;
        end
      end
      OP_JZ, OP_JNZ: begin
        if ((opnd.acc == 8'h00) == (instr_r.op == OP_JZ)) begin
          res_c.pc = rel_short;
        end
      end
      OP_SHORT_JUMP: res_c.pc = rel_short;
      OP_JUMP_IND: res_c.pc = 16'(opnd.data_pointer + {8'h00, opnd.acc});
      OP_LONG_JUMP: res_c.pc = {instr_r.b1, instr_r.b2};
      OP_LONG_CALL: begin
        res_c.pc = {instr_r.b1, instr_r.b2};
        res_c.push_pc = 1'b1;
      end
      OP_PAGE_JUMP: res_c.pc = page_tgt;
      OP_PAGE_CALL: begin
        res_c.pc = page_tgt;
        res_c.push_pc = 1'b1;
      end
      OP_RET, OP_IRQ_RET: begin
        res_c.pc = opnd.stack_pc;
        res_c.pop_pc = 1'b1;
        res_c.irq_release = instr_r.op == OP_IRQ_RET;
      end
      OP_CMP_DIR, OP_CMP_IMM: begin
        if (opnd.acc != (instr_r.op == OP_CMP_DIR ? opnd.dir_byte : instr_r.b1)) begin
          res_c.pc = rel_long;
        end
      end
      OP_CMP_IND, OP_CMP_REG: begin
        if ((instr_r.op[3] ? opnd.reg_byte : opnd.ind_byte) != instr_r.b1) begin
          res_c.pc = rel_long;
        end
      end
      OP_DEC_REG, OP_DEC_DIR: begin
        res_c.byte_we = 1'b1;
        res_c.byte_val = dec_val;
        res_c.byte_to_reg = instr_r.op != OP_DEC_DIR;
        if (dec_val != 8'h00) begin
          res_c.pc = instr_r.op == OP_DEC_DIR ? rel_long : rel_short;
        end
      end
      OP_NOP: res_c.pc = pc_after;
      // Other groups are passed back untouched
      default: res_c.unhandled = 1'b1;
    endcase
  end

  assign accept = instr_valid && instr_ready;
  assign finish = (st_r == ST_EXEC) && tick && (left_r == CYC_SHORT);

  // Sequencer next values
  always_comb begin
    st_nxt = st_r;
    instr_nxt = instr_r;
    left_nxt = left_r;
    seen_nxt = seen_r;
    res_nxt = res_r;
    done_nxt = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (accept) begin
          st_nxt = ST_EXEC;
          instr_nxt = instr;
          left_nxt = op_cycles(instr.op);
          seen_nxt = 2'h0;
        end
      end
      ST_EXEC: begin
        if (tick) begin
          left_nxt = 2'(left_r - 2'h1);
          seen_nxt = 2'(seen_r + 2'h1);
        end
        if (finish) begin
          st_nxt = ST_IDLE;
          res_nxt = res_c;
          done_nxt = 1'b1;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= ST_IDLE;
      instr_r <= '0;
      left_r <= 2'h0;
      seen_r <= 2'h0;
      res_r <= '0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      instr_r <= instr_nxt;
      left_r <= left_nxt;
      seen_r <= seen_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
    end
  end

  assign instr_ready = (st_r == ST_IDLE) && rst_sync_b;
  assign done = done_r;
  assign res = res_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  and_carry_a: assert property (done_r && instr_r.op == OP_AND_C_BIT |->
    seen_r == CYC_LONG && res_r.carry_we && res_r.carry == $past(opnd.carry & opnd.bit_val))
    else $error("carry AND bit wrong");
  and_not_a: assert property (done_r && instr_r.op == OP_AND_C_NBIT |->
    res_r.carry == $past(opnd.carry & ~opnd.bit_val) && !res_r.bit_we && seen_r == CYC_LONG)
    else $error("carry AND inverted bit wrong");
  or_carry_a: assert property (done_r && instr_r.op == OP_OR_C_BIT |->
    res_r.carry == $past(opnd.carry | opnd.bit_val) && seen_r == CYC_LONG)
    else $error("carry OR bit wrong");
  or_not_a: assert property (done_r && instr_r.op == OP_OR_C_NBIT |->
    res_r.carry == $past(opnd.carry | ~opnd.bit_val) && seen_r == CYC_LONG)
    else $error("carry OR inverted bit wrong");
  bit_to_carry_a: assert property (done_r && instr_r.op == OP_MOV_C_BIT |->
    seen_r == CYC_SHORT && res_r.carry == $past(opnd.bit_val))
    else $error("bit to carry wrong");
  carry_to_bit_a: assert property (done_r && instr_r.op == OP_MOV_BIT_C |->
    res_r.bit_we && res_r.bit_val == $past(opnd.carry) && seen_r == CYC_LONG)
    else $error("carry to bit wrong");
  test_clear_a: assert property (done_r && instr_r.op == OP_TEST_CLR |->
    res_r.bit_we == $past(opnd.bit_val) && !res_r.bit_val)
    else $error("bit test and clear wrong");
  page_keep_a: assert property (done_r && instr_r.op[4:0] == 5'h01 |->
    res_r.pc[15:PAGE_BITS] == pc_after[15:PAGE_BITS] && res_r.pc[7:0] == instr_r.b1)
    else $error("page target left its page");
  long_target_a: assert property (done_r && instr_r.op == OP_LONG_CALL |->
    res_r.pc == {instr_r.b1, instr_r.b2} && res_r.push_pc && res_r.ret_pc == pc_after)
    else $error("long call target wrong");
  irq_return_a: assert property (done_r && instr_r.op == OP_IRQ_RET |->
    res_r.irq_release && res_r.pop_pc && res_r.pc == $past(opnd.stack_pc))
    else $error("interrupt return wrong");
  quick_op_a: assert property (accept && op_cycles(instr.op) == CYC_SHORT |->
    ##[1:QUICK_MAX] done_r) else $error("one-cycle op overran");

  cover_test_clear_taken: cover property (done_r && instr_r.op == OP_TEST_CLR && res_r.bit_we);
  cover_dec_loop: cover property (done_r && res_r.byte_we && res_r.pc != pc_after);
  cover_call: cover property (done_r && res_r.push_pc);
  cover_back_to_back: cover property (done_r ##[1:64] done_r);

endmodule

// ===== inc/bitbranch_pkg.sv
package bitbranch_pkg;

  // Core clocks per machine cycle
  localparam int CLKS_PER_MCYCLE = 12;
  // Machine cycle counts
  localparam logic [1:0] CYC_SHORT = 2'h1;
  localparam logic [1:0] CYC_LONG = 2'h2;
  // Instruction lengths in bytes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  // Width of the in-page target field
  localparam int PAGE_BITS = 11;

  // Carry and bit group
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_CLR_BIT = 8'hC2;
  localparam logic [7:0] OP_SET_C = 8'hD3;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_INV_C = 8'hB3;
  localparam logic [7:0] OP_INV_BIT = 8'hB2;
  localparam logic [7:0] OP_AND_C_BIT = 8'h82;
  localparam logic [7:0] OP_AND_C_NBIT = 8'hB0;
  localparam logic [7:0] OP_OR_C_BIT = 8'h72;
  localparam logic [7:0] OP_OR_C_NBIT = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  // Program flow group
  localparam logic [7:0] OP_PAGE_JUMP = 8'b???0_0001;
  localparam logic [7:0] OP_PAGE_CALL = 8'b???1_0001;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_IRQ_RET = 8'h32;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_JUMP_IND = 8'h73;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_TEST_CLR = 8'h10;
  localparam logic [7:0] OP_CMP_DIR = 8'hB5;
  localparam logic [7:0] OP_CMP_IMM = 8'hB4;
  localparam logic [7:0] OP_CMP_IND = 8'b1011_011?;
  localparam logic [7:0] OP_CMP_REG = 8'b1011_1???;
  localparam logic [7:0] OP_DEC_REG = 8'b1101_1???;
  localparam logic [7:0] OP_DEC_DIR = 8'hD5;
  localparam logic [7:0] OP_NOP = 8'h00;

  // Instruction as presented by the fetch unit
  typedef struct packed {
    logic [7:0] op;   // Opcode byte
    logic [7:0] b1;   // Second byte
    logic [7:0] b2;   // Third byte
    logic [15:0] pc;  // Address of the opcode byte
  } instr_t;

  // Operand values returned by the core for the current request
  typedef struct packed {
    logic [7:0] acc;        // Accumulator
    logic [15:0] data_pointer;  // Data pointer
    logic carry;            // Carry flag
    logic bit_val;          // Addressed bit
    logic [7:0] dir_byte;   // Direct byte
    logic [7:0] reg_byte;   // Selected working register
    logic [7:0] ind_byte;   // Byte addressed through R0/R1
    logic [15:0] stack_pc;  // Address popped from the stack
  } opnd_t;

  // Operand addresses asked of the core
  typedef struct packed {
    logic [7:0] dir_addr;  // Direct byte address
    logic dir_is_sfr;      // Direct address is a special function register
    logic [7:0] bit_addr;  // Bit address
    logic [2:0] reg_sel;   // Working register number
    logic ind_sel;         // Pointer register, 0 for R0, 1 for R1
  } oreq_t;

  // Results handed back at completion
  typedef struct packed {
    logic [15:0] pc;      // Next program counter
    logic [15:0] ret_pc;  // Return address to push
    logic carry;          // New carry
    logic carry_we;       // Carry write
    logic bit_val;        // New bit value
    logic bit_we;         // Bit write
    logic [7:0] byte_val; // New byte value
    logic byte_we;        // Byte write
    logic byte_to_reg;    // Byte goes to working register, else direct
    logic push_pc;        // Push return address
    logic pop_pc;         // Stack pop was consumed
    logic irq_release;    // Release active interrupt level
    logic unhandled;      // Opcode outside this group
  } res_t;

  // Machine cycles for an opcode
  function automatic logic [1:0] op_cycles(input logic [7:0] op);
    logic [1:0] c;
    c = CYC_LONG;
    if (op == OP_CLR_C || op == OP_CLR_BIT || op == OP_SET_C || op == OP_SET_BIT ||
        op == OP_INV_C || op == OP_INV_BIT || op == OP_MOV_C_BIT || op == OP_NOP) begin
      c = CYC_SHORT;
    end
    return c;
  endfunction

  // Instruction length in bytes
  function automatic logic [1:0] op_len(input logic [7:0] op);
    logic [1:0] n;
    n = LEN_TWO;
    casez (op)
      OP_CLR_C, OP_SET_C, OP_INV_C, OP_RET, OP_IRQ_RET, OP_JUMP_IND, OP_NOP: n = LEN_ONE;
      OP_DEC_REG: n = LEN_TWO;
      OP_LONG_CALL, OP_LONG_JUMP, OP_JB, OP_JNB, OP_TEST_CLR, OP_DEC_DIR,
      8'b1011_01??, OP_CMP_REG: n = LEN_THREE;
      default: n = LEN_TWO;
    endcase
    return n;
  endfunction

  // Add a signed offset byte to an address
  function automatic logic [15:0] rel_add(input logic [15:0] base, input logic [7:0] off);
    return 16'(base + {{8{off[7]}}, off});
  endfunction

endpackage

// ===== rtl/mcycle_divider.sv
`timescale 1ns/1ps
module mcycle_divider
  import bitbranch_pkg::*;
#(
  parameter int DIV = CLKS_PER_MCYCLE
) (
  input wire logic clk,     // Core clock
  input wire logic rst_b,   // Synchronised reset, active low
  output logic tick         // One-cycle pulse per machine cycle
);

  logic [7:0] cnt_r;    // Clocks into the machine cycle
  logic [7:0] cnt_nxt;  // Next count
  logic tick_r;         // Registered pulse
  logic tick_nxt;       // Next pulse

  // Wrap the count and flag the last clock
  always_comb begin
    tick_nxt = (cnt_r == 8'(DIV - 1));
    cnt_nxt = tick_nxt ? 8'h00 : 8'(cnt_r + 8'h01);
  end

  // Register the divider
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

// ===== verification/opnd_core_model.sv
`timescale 1ns/1ps
module opnd_core_model
  import bitbranch_pkg::*;
(
  input wire logic clk,          // Core clock
  input wire logic rst_b,        // Reset, active low
  input wire logic instr_valid,  // Instruction offered to the decoder
  input wire logic instr_ready,  // Decoder idle
  input wire opnd_t cfg,         // Core state for the next instruction
  input wire oreq_t oreq,        // Operand addresses asked by the decoder
  output opnd_t opnd             // Operand values returned
);
  opnd_t snap_r;  // Core state frozen when an instruction is taken

  // Freeze the core state at accept so operands stay stable during execution
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      snap_r <= '0;
    end else if (instr_valid && instr_ready) begin
      snap_r <= cfg;
    end
  end

  // Answer the address lines; Rn holds base plus n
  always_comb begin
    opnd_t v;
    v = snap_r;
    v.reg_byte = 8'(snap_r.reg_byte + 8'(oreq.reg_sel));
    v.ind_byte = snap_r.ind_byte ^ 8'(snap_r.reg_byte + 8'(oreq.ind_sel));
    if (instr_ready) begin
      // Idle: the lines carry no valid data, so show the inverse
      v = opnd_t'(~v);
    end
    opnd = v;
  end
endmodule

// ===== verification/bit_and_branch_decoder_tb.sv
`timescale 1ns/1ps
module bit_and_branch_decoder_tb;
  import bitbranch_pkg::*;
  localparam int DIV = 3;                 // Shortened machine cycle
  localparam int NROW = 40;               // Table rows
  localparam logic [15:0] PC0 = 16'h07FE; // Opcode address, next page is two bytes on
  typedef struct {
    instr_t i;
    opnd_t o;
    res_t e;
    logic [1:0] cy;
  } row_t;
  logic clk, rst_b, instr_valid, instr_ready, done, took;  // Bench side signals
  instr_t instr;  // Instruction offered
  oreq_t oreq;    // Operand addresses
  opnd_t opnd;    // Operands from the core model
  opnd_t cfg;     // Core state set by the bench
  res_t res;      // Results
  int num_errors, num_checks, lat, l1, l2;
  row_t rows[NROW];

  bit_and_branch_decoder #(.DIV(DIV)) uut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .oreq(oreq), .opnd(opnd), .done(done), .res(res));
  opnd_core_model core (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .cfg(cfg), .oreq(oreq), .opnd(opnd));

  // Clock, 4 ns period
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Remember whether the last edge took an instruction
  always @(posedge clk) took <= instr_valid && instr_ready;

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim;
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Step to just after the next rising edge
  task automatic step;
    @(posedge clk);
    #1;
  endtask

  // Write strobes, flags and the written values only
  function automatic logic [31:0] view(input res_t x);
    return {14'h0, x.carry_we, x.bit_we, x.byte_we, x.push_pc, x.pop_pc, x.irq_release,
            x.unhandled, x.carry & x.carry_we, x.bit_val & x.bit_we,
            x.byte_val & {8{x.byte_we}}, x.byte_to_reg & x.byte_we};
  endfunction

  // Build a row: cb = {carry, bit}, we = {carry, bit, byte}, fl = {push, pop, irq, unh, reg}
  function automatic row_t mk(input logic [7:0] op, b1, b2, acc, input logic [1:0] cb,
      input logic [7:0] dir, input logic [1:0] ln, input logic [15:0] epc,
      input logic [1:0] cy, input logic [2:0] we, input logic [1:0] ecb,
      input logic [7:0] eby, input logic [4:0] fl);
    row_t r;
    r.i = '{op: op, b1: b1, b2: b2, pc: PC0};
    r.o = '{acc: acc, data_pointer: 16'h1234, carry: cb[1], bit_val: cb[0], dir_byte: dir,
            reg_byte: 8'h10, ind_byte: 8'h30, stack_pc: 16'h4321};
    r.e = '{pc: epc, ret_pc: 16'(PC0 + 16'(ln)), carry: ecb[1], carry_we: we[2],
            bit_val: ecb[0], bit_we: we[1], byte_val: eby, byte_we: we[0],
            byte_to_reg: fl[0], push_pc: fl[4], pop_pc: fl[3], irq_release: fl[2],
            unhandled: fl[1]};
    r.cy = cy;
    return r;
  endfunction

  // Offer one instruction, wait for accept and completion, check results
  task automatic run_row(input row_t r);
    int n;
    instr = r.i;
    cfg = r.o;
    instr_valid = 1'h1;
    n = 0;
    do begin
      step();
      n++;
    end while (took !== 1'h1 && n < 50);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
    instr_valid = 1'h0;
    chk({oreq.dir_addr, oreq.bit_addr, oreq.dir_is_sfr}, {r.i.b1, r.i.b1, r.i.b1[7]});
    chk({oreq.reg_sel, oreq.ind_sel}, {r.i.op[2:0], r.i.op[0]});
    lat = 0;
    do begin
      step();
      lat++;
    end while (done !== 1'h1 && lat < 40);
    if (lat >= 40) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
    chk({res.pc, res.ret_pc}, {r.e.pc, r.e.ret_pc});
    chk(view(res), view(r.e));
    if (r.cy == CYC_SHORT) begin
      l1 = lat;
      chk(32'(lat >= 1 && lat <= DIV + 1), 32'h1);
    end else begin
      l2 = lat;
      chk(32'(lat >= DIV + 1 && lat <= 2 * DIV + 1), 32'h1);
    end
  endtask

  initial begin
    rst_b = 1'h0;
    instr_valid = 1'h0;
    instr = '0;
    cfg = '0;
    num_errors = 0;
    num_checks = 0;
    l1 = 0;
    l2 = 0;
    // Direct operands in the table never name the accumulator
    rows = '{
      mk(8'h82, 8'h85, 8'h00, 8'h00, 2'h2, 8'h00, 2'h2, 16'h0800, 2'h2, 3'h4, 2'h0, 8'h00, 5'h00),
      mk(8'hB0, 8'h05, 8'h00, 8'h00, 2'h2, 8'h00, 2'h2, 16'h0800, 2'h2, 3'h4, 2'h2, 8'h00, 5'h00),
      mk(8'h72, 8'h05, 8'h00, 8'h00, 2'h1, 8'h00, 2'h2, 16'h0800, 2'h2, 3'h4, 2'h2, 8'h00, 5'h00),
      mk(8'hA0, 8'h05, 8'h00, 8'h00, 2'h1, 8'h00, 2'h2, 16'h0800, 2'h2, 3'h4, 2'h0, 8'h00, 5'h00),
      mk(8'hA2, 8'h05, 8'h00, 8'h00, 2'h1, 8'h00, 2'h2, 16'h0800, 2'h1, 3'h4, 2'h2, 8'h00, 5'h00),
      mk(8'h92, 8'h05, 8'h00, 8'h00, 2'h2, 8'h00, 2'h2, 16'h0800, 2'h2, 3'h2, 2'h1, 8'h00, 5'h00),
      mk(8'hC3, 8'h00, 8'h00, 8'h00, 2'h3, 8'h00, 2'h1, 16'h07FF, 2'h1, 3'h4, 2'h0, 8'h00, 5'h00),
      mk(8'hD3, 8'h00, 8'h00, 8'h00, 2'h0, 8'h00, 2'h1, 16'h07FF, 2'h1, 3'h4, 2'h2, 8'h00, 5'h00),
      mk(8'hB3, 8'h00, 8'h00, 8'h00, 2'h2, 8'h00, 2'h1, 16'h07FF, 2'h1, 3'h4, 2'h0, 8'h00, 5'h00),
      mk(8'hC2, 8'h05, 8'h00, 8'h00, 2'h1, 8'h00, 2'h2, 16'h0800, 2'h1, 3'h2, 2'h0, 8'h00, 5'h00),
      mk(8'hD2, 8'h05, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2, 16'h0800, 2'h1, 3'h2, 2'h1, 8'h00, 5'h00),
      mk(8'hB2, 8'h05, 8'h00, 8'h00, 2'h1, 8'h00, 2'h2, 16'h0800, 2'h1, 3'h2, 2'h0, 8'h00, 5'h00),
      mk(8'h10, 8'h20, 8'h10, 8'h00, 2'h1, 8'h00, 2'h3, 16'h0811, 2'h2, 3'h2, 2'h0, 8'h00, 5'h00),
      mk(8'h10, 8'h20, 8'h10, 8'h00, 2'h0, 8'h00, 2'h3, 16'h0801, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h20, 8'h20, 8'h10, 8'h00, 2'h0, 8'h00, 2'h3, 16'h0801, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h20, 8'h20, 8'h10, 8'h00, 2'h1, 8'h00, 2'h3, 16'h0811, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h30, 8'h20, 8'hF0, 8'h00, 2'h0, 8'h00, 2'h3, 16'h07F1, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h40, 8'h80, 8'h00, 8'h00, 2'h2, 8'h00, 2'h2, 16'h0780, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h50, 8'h80, 8'h00, 8'h00, 2'h2, 8'h00, 2'h2, 16'h0800, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h60, 8'h7F, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2, 16'h087F, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h70, 8'h7F, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2, 16'h0800, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h73, 8'h00, 8'h00, 8'hF0, 2'h0, 8'h00, 2'h1, 16'h1324, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'hB5, 8'h30, 8'h10, 8'h05, 2'h0, 8'h05, 2'h3, 16'h0801, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'hB5, 8'h30, 8'h10, 8'h05, 2'h0, 8'h06, 2'h3, 16'h0811, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'hB4, 8'h06, 8'h10, 8'h05, 2'h0, 8'h00, 2'h3, 16'h0811, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'hBA, 8'h12, 8'h10, 8'h00, 2'h0, 8'h00, 2'h3, 16'h0801, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'hBF, 8'h12, 8'h10, 8'h00, 2'h0, 8'h00, 2'h3, 16'h0811, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'hB7, 8'h21, 8'h10, 8'h00, 2'h0, 8'h00, 2'h3, 16'h0801, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'hB6, 8'h21, 8'h10, 8'h00, 2'h0, 8'h00, 2'h3, 16'h0811, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'hD9, 8'h10, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2, 16'h0810, 2'h2, 3'h1, 2'h0, 8'h10, 5'h01),
      mk(8'hD5, 8'h40, 8'h10, 8'h00, 2'h0, 8'h01, 2'h3, 16'h0801, 2'h2, 3'h1, 2'h0, 8'h00, 5'h00),
      mk(8'hE1, 8'h34, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2, 16'h0F34, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h71, 8'h00, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2, 16'h0B00, 2'h2, 3'h0, 2'h0, 8'h00, 5'h10),
      mk(8'h12, 8'hAB, 8'hCD, 8'h00, 2'h0, 8'h00, 2'h3, 16'hABCD, 2'h2, 3'h0, 2'h0, 8'h00, 5'h10),
      mk(8'h02, 8'hAB, 8'hCD, 8'h00, 2'h0, 8'h00, 2'h3, 16'hABCD, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h22, 8'h00, 8'h00, 8'h00, 2'h0, 8'h00, 2'h1, 16'h4321, 2'h2, 3'h0, 2'h0, 8'h00, 5'h08),
      mk(8'h32, 8'h00, 8'h00, 8'h00, 2'h0, 8'h00, 2'h1, 16'h4321, 2'h2, 3'h0, 2'h0, 8'h00, 5'h0C),
      mk(8'h80, 8'h02, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2, 16'h0802, 2'h2, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'h00, 8'h00, 8'h00, 8'h00, 2'h0, 8'h00, 2'h1, 16'h07FF, 2'h1, 3'h0, 2'h0, 8'h00, 5'h00),
      mk(8'hA5, 8'h00, 8'h00, 8'h00, 2'h0, 8'h00, 2'h2, 16'h0800, 2'h2, 3'h0, 2'h0, 8'h00, 5'h02)};
    repeat (8) @(posedge clk);
    #1;
    chk({instr_ready, done, res.pc}, 32'h0);
    rst_b = 1'h1;
    // Back to back through the table
    for (int k = 0; k < NROW; k++) begin
      run_row(rows[k]);
    end
    // Steady phase: a two-cycle op takes one machine cycle more than a one-cycle op
    chk(32'(l2 - l1), 32'(DIV));
    // Reset in mid-execution, then a long call must still run whole
    instr = rows[0].i;
    cfg = rows[0].o;
    instr_valid = 1'h1;
    step();
    step();
    instr_valid = 1'h0;
    rst_b = 1'h0;
    step();
    chk({instr_ready, done, res.pc}, 32'h0);
    rst_b = 1'h1;
    run_row(rows[33]);
    end_sim();
  end
endmodule
